// *** pdc_pkg.sv ***
package pdc_pkg;

  // Register bank geometry
  localparam int PDC_NREG = 11;
  localparam int PDC_AW = 7;

  // Printed register offsets
  localparam logic [6:0] PDC_OFF_FB_PHASE_HI = 7'h00;
  localparam logic [6:0] PDC_OFF_FB_LOW = 7'h01;
  localparam logic [6:0] PDC_OFF_FB2_LOW = 7'h02;
  localparam logic [6:0] PDC_OFF_FB2_MSB_BYP = 7'h03;
  localparam logic [6:0] PDC_OFF_IN_PHASE_HI = 7'h04;
  localparam logic [6:0] PDC_OFF_IN_LOW = 7'h05;
  localparam logic [6:0] PDC_OFF_PREDIV_MSB = 7'h08;
  localparam logic [6:0] PDC_OFF_PREDIV_LOW = 7'h09;
  localparam logic [6:0] PDC_OFF_VCXO_BYP = 7'h0a;
  localparam logic [6:0] PDC_OFF_DBL_SRC = 7'h0c;
  localparam logic [6:0] PDC_OFF_LOCK_SER = 7'h1f;

  // Storage slot of each register
  localparam int PDC_IDX_FB_PHASE_HI = 0;
  localparam int PDC_IDX_FB_LOW = 1;
  localparam int PDC_IDX_FB2_LOW = 2;
  localparam int PDC_IDX_FB2_MSB_BYP = 3;
  localparam int PDC_IDX_IN_PHASE_HI = 4;
  localparam int PDC_IDX_IN_LOW = 5;
  localparam int PDC_IDX_PREDIV_MSB = 6;
  localparam int PDC_IDX_PREDIV_LOW = 7;
  localparam int PDC_IDX_VCXO_BYP = 8;
  localparam int PDC_IDX_DBL_SRC = 9;
  localparam int PDC_IDX_LOCK_SER = 10;

  // Offsets by slot, highest slot first
  localparam logic [PDC_NREG-1:0][6:0] PDC_OFFSET = {
    PDC_OFF_LOCK_SER, PDC_OFF_DBL_SRC, PDC_OFF_VCXO_BYP, PDC_OFF_PREDIV_LOW,
    PDC_OFF_PREDIV_MSB, PDC_OFF_IN_LOW, PDC_OFF_IN_PHASE_HI, PDC_OFF_FB2_MSB_BYP,
    PDC_OFF_FB2_LOW, PDC_OFF_FB_LOW, PDC_OFF_FB_PHASE_HI};

  // Implemented bits by slot; reserved bits stay zero
  localparam logic [PDC_NREG-1:0][7:0] PDC_MASK = {
    8'hff, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff, 8'hef, 8'h81, 8'hff, 8'hff, 8'hff};

  // Power-on values: phase 101, feedback 3072, second feedback 30, input 3072, prediv 24
  localparam logic [PDC_NREG-1:0][7:0] PDC_RESET = {
    8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h1e, 8'h00, 8'hac};

  // Field positions
  localparam int PDC_PHASE_MSB = 7;
  localparam int PDC_PHASE_LSB = 5;
  localparam int PDC_FB2_PD_BIT = 4;
  localparam int PDC_HI_NIB_MSB = 3;
  localparam int PDC_FB2_MSB_BIT = 7;
  localparam int PDC_FLAG_BIT = 0;
  localparam int PDC_DBL_BIT = 7;
  localparam int PDC_SRC_BIT = 6;
  localparam int PDC_NARROW_MSB = 5;
  localparam int PDC_MASK_BIT = 7;
  localparam int PDC_WIRE_BIT = 6;
  localparam int PDC_STV_BIT = 5;
  localparam int PDC_SPV_BIT = 4;
  localparam int PDC_OCTL_MSB = 3;

  // Serial frame: read flag, 7 address bits, 8 data bits, MSB first
  localparam logic [4:0] PDC_HDR_BITS = 5'h08;
  localparam logic [4:0] PDC_FRAME_BITS = 5'h10;

endpackage

// *** pdc_reg_if.sv ***
interface pdc_reg_if;
  import pdc_pkg::*;
  logic wr_stb;
  logic [PDC_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wire_mode;

  modport port (output wr_stb, output addr, output wdata, input rdata, input wire_mode);
  modport bank (input wr_stb, input addr, input wdata, output rdata, output wire_mode);
endinterface

// *** pdc_spi_port.sv ***
module pdc_spi_port
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial control pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  // Register access
  pdc_reg_if.port regs
);

  typedef struct packed {
    logic sclk_prev;
    logic [4:0] cnt;
    logic [6:0] shift;
    logic rd;
    logic [6:0] addr;
    logic [7:0] tx;
    logic dout;
    logic drive;
    logic dat_oe;
    logic sdo_oe;
    logic wr_stb;
    logic [7:0] wdata;
  } pdc_spi_state_t;

  pdc_spi_state_t q, d;

  // Frame decode; sclk is sampled so edges are seen one clk_sys late
  always_comb begin
    d = q;
    d.wr_stb = 1'b0;
    d.sclk_prev = spi_sclk;
    if (spi_cs_n) begin
      d.cnt = 5'h00;
      d.drive = 1'b0;
      d.rd = 1'b0;
    end else if (spi_sclk && !q.sclk_prev && q.cnt < PDC_FRAME_BITS) begin
      d.shift = {q.shift[5:0], serial_data_pin_i};
      d.cnt = q.cnt + 5'h01;
      if (q.cnt == PDC_HDR_BITS - 5'h01) begin
        d.rd = q.shift[6];
        d.addr = {q.shift[5:0], serial_data_pin_i};
      end
      if (q.cnt == PDC_FRAME_BITS - 5'h01 && !q.rd) begin
        d.wr_stb = 1'b1;
        d.wdata = {q.shift[6:0], serial_data_pin_i};
      end
    end else if (!spi_sclk && q.sclk_prev && q.rd && q.cnt >= PDC_HDR_BITS && q.cnt < PDC_FRAME_BITS) begin
      // Read data leaves on falling edges so the master samples it on rising ones
      if (q.cnt == PDC_HDR_BITS) begin
        d.dout = regs.rdata[7];
        d.tx = {regs.rdata[6:0], 1'b0};
        d.drive = 1'b1;
      end else begin
        d.dout = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end
    end
    // Wire mode picks which pin drives; the other stays released
    d.dat_oe = d.drive && !regs.wire_mode;
    d.sdo_oe = d.drive && regs.wire_mode;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign serial_data_pin_o = q.dout;
  assign serial_data_pin_oe = q.dat_oe;
  assign serial_out_pin_o = q.dout;
  assign serial_out_pin_oe = q.sdo_oe;
  assign regs.wr_stb = q.wr_stb;
  assign regs.addr = q.addr;
  assign regs.wdata = q.wdata;

endmodule

// *** pdc_status_out.sv ***
module pdc_status_out
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Loop conditions and settings
  input wire logic vcxo_stage_lock_loss,
  input wire logic synth_lock_loss,
  input wire logic lock_loss_report_mask,
  input wire logic freq_doubler_sel,
  input wire logic [5:0] synth_prediv_narrow,
  // Results
  output logic lock_pin,
  output logic [5:0] synth_prediv_eff
);

  typedef struct packed {
    logic lock;
    logic [5:0] eff;
  } pdc_status_state_t;

  pdc_status_state_t q, d;

  // Lock pin falls on any reported loss; masked first-stage loss is invisible
  always_comb begin
    d = q;
    d.lock = !((vcxo_stage_lock_loss && !lock_loss_report_mask) || synth_lock_loss);
    // Doubling takes over the second-stage input, so the narrow divider means nothing
    d.eff = freq_doubler_sel ? 6'h00 : synth_prediv_narrow;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lock_pin = q.lock;
  assign synth_prediv_eff = q.eff;

endmodule

// *** pdc_divider_regs.sv ***
// Notes on behaviour
// - First feedback divider is a 12-bit read/write ratio, default 3072.
// - Feedback and input phase fields set lock-detect window; feedback phase defaults 101.
// - Offsets 0x00, 0x01, 0x02 hold feedback phase, powerdown and divider bytes.
// - Offsets 0x03, 0x04, 0x05 hold second divider MSB, bypass, input divider.
// - Offsets 0x08, 0x09, 0x0a, 0x0c hold prediv, stage bypass, doubler, source.
// - Offset 0x1f holds lock mask, wire mode, two voltage selects, output field.
// - Wire mode 0 shares data pin, out pin released; 1 drives out pin.
// - Mask set hides first-stage lock loss from lock pin; clear reports it.
// - Doubler set ignores narrow prediv; clear divides by narrow prediv.
module pdc_divider_regs
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial control pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  // Loop status
  input wire logic vcxo_stage_lock_loss,
  input wire logic synth_lock_loss,
  output logic lock_pin,
  // First stage settings
  output logic [2:0] feedback_sample_phase,
  output logic second_feedback_powerdown,
  output logic [11:0] vcxo_feedback_divider,
  output logic [8:0] second_feedback_divider,
  output logic synth_bypass_flag,
  output logic [2:0] input_sample_phase,
  output logic [11:0] vcxo_input_divider,
  output logic vcxo_stage_bypass,
  // Second stage settings
  output logic [8:0] synth_prediv_wide,
  output logic freq_doubler_sel,
  output logic output_source_sel,
  output logic [5:0] synth_prediv_narrow,
  output logic [5:0] synth_prediv_eff,
  // Interface and reporting settings
  output logic lock_loss_report_mask,
  output logic serial_wire_mode,
  output logic status_pin_voltage_sel,
  output logic serial_pin_voltage_sel,
  output logic [3:0] vcxo_out_ctrl_field
);

  typedef struct packed {
    logic [PDC_NREG-1:0][7:0] regs;
  } pdc_bank_state_t;

  typedef struct packed {
    logic hit;
    logic [3:0] idx;
  } pdc_slot_t;

  pdc_bank_state_t q, d;
  pdc_slot_t wr_slot;
  pdc_slot_t rd_slot;

  pdc_reg_if bus ();

  // Maps an address to its storage slot; unmapped addresses miss
  function automatic pdc_slot_t pdc_decode(input logic [PDC_AW-1:0] a);
    pdc_slot_t s;
    s.hit = 1'b0;
    s.idx = 4'h0;
    for (int i = 0; i < PDC_NREG; i++) begin
      if (PDC_OFFSET[i] == a) begin
        s.hit = 1'b1;
        s.idx = 4'(i);
      end
    end
    return s;
  endfunction

  // Serial front end
  pdc_spi_port u_spi (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .serial_data_pin_i(serial_data_pin_i),
    .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe(serial_data_pin_oe),
    .serial_out_pin_o(serial_out_pin_o),
    .serial_out_pin_oe(serial_out_pin_oe),
    .regs(bus.port)
  );

  // Lock reporting and effective second-stage predivider
  pdc_status_out u_status (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .vcxo_stage_lock_loss(vcxo_stage_lock_loss),
    .synth_lock_loss(synth_lock_loss),
    .lock_loss_report_mask(lock_loss_report_mask),
    .freq_doubler_sel(freq_doubler_sel),
    .synth_prediv_narrow(synth_prediv_narrow),
    .lock_pin(lock_pin),
    .synth_prediv_eff(synth_prediv_eff)
  );

  // Write path; masking keeps reserved bits at zero whatever software writes
  always_comb begin
    d = q;
    wr_slot = pdc_decode(bus.addr);
    if (bus.wr_stb && wr_slot.hit) begin
      d.regs[wr_slot.idx] = bus.wdata & PDC_MASK[wr_slot.idx];
    end
  end

  // Read path; unmapped offsets answer zero
  always_comb begin
    rd_slot = pdc_decode(bus.addr);
    bus.rdata = rd_slot.hit ? (q.regs[rd_slot.idx] & PDC_MASK[rd_slot.idx]) : 8'h00;
  end

  assign bus.wire_mode = serial_wire_mode;

  // Power-on values come straight from the constant table
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q.regs <= PDC_RESET;
    end else begin
      q <= d;
    end
  end

  // Offset 0x00 and 0x01: phase, powerdown, 12-bit feedback divider
  assign feedback_sample_phase = q.regs[PDC_IDX_FB_PHASE_HI][PDC_PHASE_MSB:PDC_PHASE_LSB];
  assign second_feedback_powerdown = q.regs[PDC_IDX_FB_PHASE_HI][PDC_FB2_PD_BIT];
  assign vcxo_feedback_divider = {q.regs[PDC_IDX_FB_PHASE_HI][PDC_HI_NIB_MSB:0],
                                  q.regs[PDC_IDX_FB_LOW]};

  // Offset 0x02 and 0x03: second feedback divider and bypass flag
  assign second_feedback_divider = {q.regs[PDC_IDX_FB2_MSB_BYP][PDC_FB2_MSB_BIT],
                                    q.regs[PDC_IDX_FB2_LOW]};
  assign synth_bypass_flag = q.regs[PDC_IDX_FB2_MSB_BYP][PDC_FLAG_BIT];

  // Offset 0x04 and 0x05: input phase and input divider; bit 4 is reserved
  assign input_sample_phase = q.regs[PDC_IDX_IN_PHASE_HI][PDC_PHASE_MSB:PDC_PHASE_LSB];
  assign vcxo_input_divider = {q.regs[PDC_IDX_IN_PHASE_HI][PDC_HI_NIB_MSB:0],
                               q.regs[PDC_IDX_IN_LOW]};

  // Offset 0x08, 0x09, 0x0a, 0x0c: prediv, bypass, doubler, source
  assign synth_prediv_wide = {q.regs[PDC_IDX_PREDIV_MSB][PDC_FLAG_BIT],
                              q.regs[PDC_IDX_PREDIV_LOW]};
  assign vcxo_stage_bypass = q.regs[PDC_IDX_VCXO_BYP][PDC_FLAG_BIT];
  assign freq_doubler_sel = q.regs[PDC_IDX_DBL_SRC][PDC_DBL_BIT];
  assign output_source_sel = q.regs[PDC_IDX_DBL_SRC][PDC_SRC_BIT];
  assign synth_prediv_narrow = q.regs[PDC_IDX_DBL_SRC][PDC_NARROW_MSB:0];

  // Offset 0x1f: reporting mask, wire mode, voltage selects, output field
  assign lock_loss_report_mask = q.regs[PDC_IDX_LOCK_SER][PDC_MASK_BIT];
  assign serial_wire_mode = q.regs[PDC_IDX_LOCK_SER][PDC_WIRE_BIT];
  assign status_pin_voltage_sel = q.regs[PDC_IDX_LOCK_SER][PDC_STV_BIT];
  assign serial_pin_voltage_sel = q.regs[PDC_IDX_LOCK_SER][PDC_SPV_BIT];
  assign vcxo_out_ctrl_field = q.regs[PDC_IDX_LOCK_SER][PDC_OCTL_MSB:0];

endmodule

// *** pdc_divider_regs_chk.sv ***
module pdc_chk
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched ports
  input wire logic spi_cs_n,
  input wire logic vcxo_stage_lock_loss,
  input wire logic synth_lock_loss,
  input wire logic lock_pin,
  input wire logic lock_loss_report_mask,
  input wire logic freq_doubler_sel,
  input wire logic [5:0] synth_prediv_narrow,
  input wire logic [5:0] synth_prediv_eff,
  input wire logic serial_data_pin_oe,
  input wire logic serial_out_pin_oe,
  input wire logic serial_wire_mode,
  input wire logic [11:0] vcxo_feedback_divider,
  input wire logic [2:0] feedback_sample_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // First edge after release still shows the reset-time lock value
  property p_lock;
    $past(rstn) |-> lock_pin == !$past(synth_lock_loss || (vcxo_stage_lock_loss && !lock_loss_report_mask));
  endproperty
  a_lock: assert property (p_lock) else $error("lock pin wrong");
  property p_eff;
    $past(rstn) |-> synth_prediv_eff == ($past(freq_doubler_sel) ? 6'h00 : $past(synth_prediv_narrow));
  endproperty
  a_eff: assert property (p_eff) else $error("prediv wrong");
  property p_excl;
    !(serial_data_pin_oe && serial_out_pin_oe);
  endproperty
  a_excl: assert property (p_excl) else $error("both pins driven");
  property p_mode;
    serial_out_pin_oe |-> serial_wire_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("out pin driven in mode 0");
  // Pins released once the select has stayed high
  property p_idle;
    spi_cs_n [*4] |-> !serial_data_pin_oe && !serial_out_pin_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("pin driven while idle");
  property p_frame;
    $fell(spi_cs_n) |-> ##4 (!serial_data_pin_oe && !serial_out_pin_oe) [*8];
  endproperty
  a_frame: assert property (p_frame) else $error("pin driven in header");
  property p_stable;
    spi_cs_n [*4] |-> $stable({vcxo_feedback_divider, feedback_sample_phase, serial_wire_mode, freq_doubler_sel});
  endproperty
  a_stable: assert property (p_stable) else $error("field changed while idle");
  property p_rst;
    $rose(rstn) |-> vcxo_feedback_divider == 12'hc00 && feedback_sample_phase == 3'h5;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");

  // Main scenarios reached
  c_rd1: cover property (serial_out_pin_oe);
  c_rd0: cover property (serial_data_pin_oe);
  c_mask: cover property (vcxo_stage_lock_loss && lock_loss_report_mask && lock_pin);
endmodule

// *** test_pdc_divider_regs.sv ***
module test_pdc_divider_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, spi_cs_n = 1, spi_sclk = 0, serial_data_pin_i = 0;
  logic vcxo_stage_lock_loss = 0, synth_lock_loss = 0, lock_pin;
  logic serial_data_pin_o, serial_data_pin_oe, serial_out_pin_o, serial_out_pin_oe;
  logic second_feedback_powerdown, synth_bypass_flag, vcxo_stage_bypass, freq_doubler_sel, output_source_sel;
  logic lock_loss_report_mask, serial_wire_mode, status_pin_voltage_sel, serial_pin_voltage_sel;
  logic [2:0] feedback_sample_phase, input_sample_phase;
  logic [11:0] vcxo_feedback_divider, vcxo_input_divider;
  logic [8:0] second_feedback_divider, synth_prediv_wide;
  logic [5:0] synth_prediv_narrow, synth_prediv_eff;
  logic [3:0] vcxo_out_ctrl_field;
  logic [7:0] mem [0:127];
  logic [6:0] adr [11] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h08, 7'h09, 7'h0a, 7'h0c, 7'h1f};
  logic [31:0] seed = 32'h0000b0b9;
  int num_errors = 0, checks = 0;

  // 50 MHz
  always #10 clk_sys = ~clk_sys;

  pdc_divider_regs i_dut(.clk_sys, .rstn, .spi_cs_n, .spi_sclk, .serial_data_pin_i, .serial_data_pin_o,
    .serial_data_pin_oe, .serial_out_pin_o, .serial_out_pin_oe, .vcxo_stage_lock_loss, .synth_lock_loss,
    .lock_pin, .feedback_sample_phase, .second_feedback_powerdown, .vcxo_feedback_divider,
    .second_feedback_divider, .synth_bypass_flag, .input_sample_phase, .vcxo_input_divider, .vcxo_stage_bypass,
    .synth_prediv_wide, .freq_doubler_sel, .output_source_sel, .synth_prediv_narrow, .synth_prediv_eff,
    .lock_loss_report_mask, .serial_wire_mode, .status_pin_voltage_sel, .serial_pin_voltage_sel,
    .vcxo_out_ctrl_field);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Implemented bits; unmapped places hold none
  function automatic logic [7:0] msk(input logic [6:0] a);
    case (a)
      7'h03: return 8'h81;
      7'h04: return 8'hef;
      7'h08, 7'h0a: return 8'h01;
      7'h00, 7'h01, 7'h02, 7'h05, 7'h09, 7'h0c, 7'h1f: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  // Lock-detect phase code that software pairs with a feedback ratio
  function automatic logic [2:0] phase_for(input logic [11:0] n);
    if (n < 12'h040) return 3'h2;
    if (n < 12'h080) return 3'h3;
    if (n < 12'h100) return 3'h4;
    if (n < 12'h200) return 3'h5;
    if (n < 12'h400) return 3'h6;
    return 3'h7;
  endfunction
  // Power-on contents: ratios 3072, 30, 3072, 24 and phase 101
  task automatic preset();
    foreach (mem[i]) mem[i] = 8'h00;
    mem[0] = 8'hac;
    mem[2] = 8'h1e;
    mem[4] = 8'h0c;
    mem[9] = 8'h18;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Each sclk phase lasts several clocks so edge detection has settled before read bits are sampled
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d, input int nb, output logic [7:0] q);
    logic [15:0] w;
    logic m;
    w = {rd, a, d};
    m = mem[31][6];
    spi_cs_n <= 1'b0;
    tick(2);
    for (int i = 15; i >= 16 - nb; i--) begin
      spi_sclk <= 1'b0;
      serial_data_pin_i <= w[i];
      tick(3);
      @(negedge clk_sys);
      if (rd && i < 8) begin
        q[i] = m ? serial_out_pin_o : serial_data_pin_o;
        cmp({m ? serial_out_pin_oe : serial_data_pin_oe, m ? serial_data_pin_oe : serial_out_pin_oe}, 2);
      end
      tick(1);
      spi_sclk <= 1'b1;
      tick(3);
    end
    spi_sclk <= 1'b0;
    tick(3);
    spi_cs_n <= 1'b1;
    tick(4);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(1'b0, a, d, 16, q);
    mem[a] = d & msk(a);
  endtask
  // Readback of every mapped place and of unmapped 0x06, field outputs and lock reporting
  task automatic sweep();
    logic [7:0] q;
    logic [31:0] r;
    foreach (adr[i]) begin
      frame(1'b1, adr[i], 8'h00, 16, q);
      cmp(q, mem[adr[i]]);
    end
    frame(1'b1, 7'h06, 8'h00, 16, q);
    cmp(q, 8'h00);
    cmp(vcxo_feedback_divider, {mem[0][3:0], mem[1]});
    cmp({feedback_sample_phase, second_feedback_powerdown}, mem[0][7:4]);
    cmp({second_feedback_divider, synth_bypass_flag}, {mem[3][7], mem[2], mem[3][0]});
    cmp({input_sample_phase, vcxo_input_divider}, {mem[4][7:5], mem[4][3:0], mem[5]});
    cmp({vcxo_stage_bypass, synth_prediv_wide}, {mem[10][0], mem[8][0], mem[9]});
    cmp({freq_doubler_sel, output_source_sel, synth_prediv_narrow}, mem[12]);
    cmp({lock_loss_report_mask, serial_wire_mode, status_pin_voltage_sel, serial_pin_voltage_sel,
      vcxo_out_ctrl_field}, mem[31]);
    cmp(synth_prediv_eff, mem[12][7] ? 6'h00 : mem[12][5:0]);
    repeat (4) begin
      r = rnd();
      vcxo_stage_lock_loss <= r[0];
      synth_lock_loss <= r[1];
      tick(2);
      cmp(lock_pin, !(r[1] | (r[0] & !mem[31][7])));
    end
    $display("sweep done at %0t", $time);
  endtask

  // Main sequence
  initial begin
    logic [7:0] q;
    logic [31:0] r;
    logic [11:0] n;
    preset();
    tick(5);
    rstn <= 1'b1;
    tick(2);
    sweep();
    // Largest ratio, reserved bits, unmapped write, then an aborted frame
    foreach (adr[i]) wr(adr[i], 8'hff);
    wr(7'h06, 8'h5a);
    sweep();
    frame(1'b0, 7'h01, 8'h00, 12, q);
    wr(7'h1f, 8'h40);
    sweep();
    wr(7'h1f, 8'h80);
    sweep();
    // Ratio and its phase code written together; the shift spreads ratios over every range
    repeat (6) begin
      r = rnd();
      n = r[11:0] >> r[14:12];
      wr(7'h01, n[7:0]);
      wr(7'h00, {phase_for(n), r[15], n[11:8]});
      cmp({feedback_sample_phase, vcxo_feedback_divider}, {phase_for(n), n});
    end
    $display("phase pairing done at %0t", $time);
    repeat (3) begin
      foreach (adr[i]) begin
        r = rnd();
        wr(adr[i], r[7:0]);
      end
      sweep();
    end
    // Reset in mid-run
    rstn <= 1'b0;
    tick(2);
    preset();
    rstn <= 1'b1;
    tick(2);
    sweep();
    conclude();
  end

  // Hang guard
  initial begin
    tick(60000);
    num_errors++;
    $display("Error %0t: timeout", $time);
    conclude();
  end
endmodule

bind pdc_divider_regs pdc_chk i_chk(.clk_sys, .rstn, .spi_cs_n, .vcxo_stage_lock_loss, .synth_lock_loss, .lock_pin,
  .lock_loss_report_mask, .freq_doubler_sel, .synth_prediv_narrow, .synth_prediv_eff, .serial_data_pin_oe,
  .serial_out_pin_oe, .serial_wire_mode, .vcxo_feedback_divider, .feedback_sample_phase);
